// ---- rtl/pmic_irq_pkg.sv ----
package pmic_irq_pkg;

    // Rails 0..1 are the bucks, 2..3 the linear regulators
    localparam int NUM_RAILS = 4;
    localparam int NUM_SYNC = 17;
    localparam int CNT_W = 16;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RESET = 4'h1;
    localparam logic [3:0] ADDR_FLAG_TOP = 4'h2;
    localparam logic [3:0] ADDR_FLAG_BUCK = 4'h3;
    localparam logic [3:0] ADDR_FLAG_LIN = 4'h4;
    localparam logic [3:0] ADDR_MASK_TOP = 4'h5;
    localparam logic [3:0] ADDR_MASK_BUCK = 4'h6;
    localparam logic [3:0] ADDR_MASK_LIN = 4'h7;
    localparam logic [3:0] ADDR_STAT_TOP = 4'h8;
    localparam logic [3:0] ADDR_STAT_RAIL = 4'h9;

    // Control register fields (bits 3:0 are the rail enables)
    localparam int CTL_GEN_FIRST = 4;
    localparam int CTL_GEN_SECOND = 5;
    localparam int CTL_POLARITY = 6;
    localparam int CTL_CLK_DET = 7;
    localparam int RESET_REQ_BIT = 0;

    // Top flag, top mask and top status fields
    localparam int TOP_WARN = 0;
    localparam int TOP_SHUTDOWN = 1;
    localparam int TOP_OVERVOLT = 2;
    localparam int TOP_PIN = 3;
    localparam int TOP_CLK = 4;
    localparam int TOP_MEAS = 5;
    localparam int TOP_RESET = 6;
    localparam int STAT_BUCK_SUM = 6;
    localparam int STAT_LIN_SUM = 7;
    localparam logic [6:0] TOP_MASK_WRITABLE = 7'h39;

    // Per-rail flag and mask fields (two bits each)
    localparam int FL_ILIM = 0;
    localparam int FL_SHORT = 2;
    localparam int FL_POK = 4;
    localparam int MK_ILIM = 0;
    localparam int MK_RISE = 4;
    localparam int MK_FALL = 6;
    localparam int ST_POK = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] TOP_MASK_RST = 7'h00;
    localparam logic [3:0] RAIL_MASK_RST = 4'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Short-circuit debounce, least time, rounded up
    localparam int CLK_PERIOD_NS = 20;
    localparam int SHORT_DEBOUNCE_MS = 1;
    localparam int SHORT_DEBOUNCE_CYC =
        (SHORT_DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {BOOT_HOLD, BOOT_SETTLE, BOOT_LOAD, BOOT_RUN} boot_state_e;

endpackage : pmic_irq_pkg

// ---- rtl/pmic_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmic_sync #(
    parameter int W = 1
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_ff <= '0;
            q_out <= '0;
        end
        else if (ce_in)
        begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end

endmodule : pmic_sync
`default_nettype wire

// ---- rtl/pmic_event_interrupt_logic.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmic_event_interrupt_logic
    import pmic_irq_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = SHORT_DEBOUNCE_CYC
)
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [3:0] ILIM_IN,
    input wire logic [3:0] LOW_IN,
    input wire logic [3:0] POK_IN,
    input wire logic DIE_WARN_IN,
    input wire logic DIE_SHUTDOWN_IN,
    input wire logic OVERVOLT_IN,
    input wire logic SYNC_CLK_PRESENT_IN,
    input wire logic OTP_RESET_MASK_IN,
    input wire logic MEAS_DONE_IN,
    output logic [7:0] RDATA_OUT,
    output logic [3:0] REG_EN_OUT,
    output logic GENERAL_OUTPUT_FIRST_OUT,
    output logic GENERAL_OUTPUT_SECOND_OUT,
    output logic POWER_OK_PIN_OUT,
    output logic INTERRUPT_PIN_N_OUT
);

    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYCLES - 1);

    boot_state_e state_ff;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [6:0] top_flag_ff, top_mask_ff, top_set;
    logic [3:0] ilim_mask_ff, rise_mask_ff, fall_mask_ff;
    logic [3:0] ilim_flag, short_flag, pok_flag, pok_prev, short_hit;
    logic [3:0] ilim_clr, short_clr, pok_clr;
    logic [NUM_SYNC-1:0] syn;
    logic [3:0] ilim_s, low_s, pok_s;
    logic warn_s, sd_s, ovp_s, clk_s, otp_s;
    logic clk_prev_ff, pin_ok, pin_ok_ff, run;
    logic wr_buck, wr_lin, sw_reset, buck_sum, lin_sum;

    pmic_sync #(.W(NUM_SYNC)) u_sync
    (
        .clk_in(MCLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CE_IN),
        .d_in({OTP_RESET_MASK_IN, SYNC_CLK_PRESENT_IN, OVERVOLT_IN, DIE_SHUTDOWN_IN,
               DIE_WARN_IN, POK_IN, LOW_IN, ILIM_IN}),
        .q_out(syn)
    );

    assign ilim_s = syn[3:0];
    assign low_s = syn[7:4];
    assign pok_s = syn[11:8];
    assign warn_s = syn[12];
    assign sd_s = syn[13];
    assign ovp_s = syn[14];
    assign clk_s = syn[15];
    assign otp_s = syn[16];

    assign run = (state_ff == BOOT_RUN);
    assign wr_buck = WR_IN && (ADDR_IN == ADDR_FLAG_BUCK);
    assign wr_lin = WR_IN && (ADDR_IN == ADDR_FLAG_LIN);
    assign sw_reset = WR_IN && (ADDR_IN == ADDR_RESET) && WDATA_IN[RESET_REQ_BIT];
    assign ilim_clr = {wr_lin ? WDATA_IN[FL_ILIM+:2] : 2'b00,
                       wr_buck ? WDATA_IN[FL_ILIM+:2] : 2'b00};
    assign short_clr = {wr_lin ? WDATA_IN[FL_SHORT+:2] : 2'b00,
                        wr_buck ? WDATA_IN[FL_SHORT+:2] : 2'b00};
    assign pok_clr = {wr_lin ? WDATA_IN[FL_POK+:2] : 2'b00,
                      wr_buck ? WDATA_IN[FL_POK+:2] : 2'b00};

    // Boot walk waits two edges so the stored mask has passed the synchroniser
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            state_ff <= BOOT_HOLD;
        else if (CE_IN)
        begin
            case (state_ff)
                BOOT_HOLD: state_ff <= BOOT_SETTLE;
                BOOT_SETTLE: state_ff <= BOOT_LOAD;
                BOOT_LOAD: state_ff <= BOOT_RUN;
                BOOT_RUN: state_ff <= sw_reset ? BOOT_HOLD : BOOT_RUN;
                default: state_ff <= BOOT_HOLD;
            endcase
        end
    end

    // Faults beat host writes so a rail cannot be re-enabled during die shutdown or overvoltage
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if ((ADDR_IN == ADDR_CTRL) && WR_IN)
            nxt_ctrl = WDATA_IN;
        nxt_ctrl[3:0] = nxt_ctrl[3:0] & ~short_hit;
        if (sd_s || ovp_s)
        begin
            nxt_ctrl[3:0] = 4'h0;
            nxt_ctrl[CTL_GEN_FIRST] = 1'b0;
            nxt_ctrl[CTL_GEN_SECOND] = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            ctrl_ff <= CTRL_RST;
        else if (CE_IN)
            ctrl_ff <= run ? nxt_ctrl : CTRL_RST;
    end

    assign REG_EN_OUT = ctrl_ff[3:0];
    assign GENERAL_OUTPUT_FIRST_OUT = ctrl_ff[CTL_GEN_FIRST];
    assign GENERAL_OUTPUT_SECOND_OUT = ctrl_ff[CTL_GEN_SECOND];

    // Masks; the reset mask bit is loaded only from stored bits
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            top_mask_ff <= TOP_MASK_RST;
            ilim_mask_ff <= RAIL_MASK_RST;
            rise_mask_ff <= RAIL_MASK_RST;
            fall_mask_ff <= RAIL_MASK_RST;
        end
        else if (CE_IN)
        begin
            if (!run)
            begin
                top_mask_ff <= TOP_MASK_RST;
                ilim_mask_ff <= RAIL_MASK_RST;
                rise_mask_ff <= RAIL_MASK_RST;
                fall_mask_ff <= RAIL_MASK_RST;
                if (state_ff == BOOT_LOAD)
                    top_mask_ff[TOP_RESET] <= otp_s;
            end
            else if (WR_IN)
            begin
                if (ADDR_IN == ADDR_MASK_TOP)
                    top_mask_ff <= (WDATA_IN[6:0] & TOP_MASK_WRITABLE) |
                                   (top_mask_ff & ~TOP_MASK_WRITABLE);
                if (ADDR_IN == ADDR_MASK_BUCK)
                begin
                    ilim_mask_ff[1:0] <= WDATA_IN[MK_ILIM+:2];
                    rise_mask_ff[1:0] <= WDATA_IN[MK_RISE+:2];
                    fall_mask_ff[1:0] <= WDATA_IN[MK_FALL+:2];
                end
                if (ADDR_IN == ADDR_MASK_LIN)
                begin
                    ilim_mask_ff[3:2] <= WDATA_IN[MK_ILIM+:2];
                    rise_mask_ff[3:2] <= WDATA_IN[MK_RISE+:2];
                    fall_mask_ff[3:2] <= WDATA_IN[MK_FALL+:2];
                end
            end
        end
    end

    for (genvar r = 0; r < NUM_RAILS; r++)
    begin : g_rail
        logic [CNT_W-1:0] cnt_ff;
        logic ilim_q, short_q, pok_q, prev_q, pok_set;

        // One debounce covers both the after-enable and in-operation cases
        assign short_hit[r] = run && ctrl_ff[r] && low_s[r] && (cnt_ff == SHORT_LAST);
        assign pok_set = (pok_s[r] && !prev_q && !rise_mask_ff[r]) ||
                         (!pok_s[r] && prev_q && !fall_mask_ff[r]);

        always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
        begin
            if (!RESET_N_IN)
            begin
                cnt_ff <= '0;
                ilim_q <= 1'b0;
                short_q <= 1'b0;
                pok_q <= 1'b0;
                prev_q <= 1'b0;
            end
            else if (CE_IN)
            begin
                if (!run || !ctrl_ff[r] || !low_s[r])
                    cnt_ff <= '0;
                else if (!short_hit[r])
                    cnt_ff <= cnt_ff + CNT_W'(1);
                prev_q <= pok_s[r];
                if (!run)
                begin
                    ilim_q <= 1'b0;
                    short_q <= 1'b0;
                    pok_q <= 1'b0;
                end
                else
                begin
                    // Live limit re-sets the flag, so a clear cannot stick
                    ilim_q <= (ilim_q && !ilim_clr[r]) ||
                              (ilim_s[r] && !ilim_mask_ff[r]);
                    short_q <= (short_q && !short_clr[r]) || short_hit[r];
                    pok_q <= (pok_q && !pok_clr[r]) || pok_set;
                end
            end
        end

        assign ilim_flag[r] = ilim_q;
        assign short_flag[r] = short_q;
        assign pok_flag[r] = pok_q;
        assign pok_prev[r] = prev_q;
    end

    // Disabled rails do not drag the pin status down
    assign pin_ok = (&(~ctrl_ff[3:0] | pok_s)) && !top_flag_ff[TOP_SHUTDOWN] &&
                    !top_flag_ff[TOP_OVERVOLT];

    always_comb
    begin
        top_set = 7'h00;
        top_set[TOP_WARN] = warn_s && !top_mask_ff[TOP_WARN];
        top_set[TOP_SHUTDOWN] = sd_s;
        top_set[TOP_OVERVOLT] = ovp_s;
        top_set[TOP_PIN] = pin_ok_ff && !pin_ok && !top_mask_ff[TOP_PIN];
        top_set[TOP_CLK] = ((clk_s != clk_prev_ff) ||
                            (ctrl_ff[CTL_CLK_DET] && !clk_s)) &&
                           !top_mask_ff[TOP_CLK];
        top_set[TOP_MEAS] = MEAS_DONE_IN && !top_mask_ff[TOP_MEAS];
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            top_flag_ff <= 7'h00;
            clk_prev_ff <= 1'b0;
            pin_ok_ff <= 1'b0;
            POWER_OK_PIN_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            clk_prev_ff <= clk_s;
            pin_ok_ff <= pin_ok;
            POWER_OK_PIN_OUT <= pin_ok ^ ctrl_ff[CTL_POLARITY];
            if (!run)
            begin
                top_flag_ff <= 7'h00;
                if (state_ff == BOOT_LOAD)
                    top_flag_ff[TOP_RESET] <= !otp_s;
            end
            else if (WR_IN && (ADDR_IN == ADDR_FLAG_TOP))
                top_flag_ff <= (top_flag_ff & ~WDATA_IN[6:0]) | top_set;
            else
                top_flag_ff <= top_flag_ff | top_set;
        end
    end

    assign buck_sum = |{ilim_flag[1:0], short_flag[1:0], pok_flag[1:0]};
    assign lin_sum = |{ilim_flag[3:2], short_flag[3:2], pok_flag[3:2]};

    // Masks gate the flag set, so any flag held counts as pending
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            INTERRUPT_PIN_N_OUT <= 1'b1;
        else if (CE_IN)
            INTERRUPT_PIN_N_OUT <= !(|top_flag_ff || buck_sum || lin_sum);
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            RDATA_OUT <= RDATA_RST;
        else if (CE_IN)
        begin
            RDATA_OUT <= RDATA_RST;
            if (RD_IN)
            begin
                case (ADDR_IN)
                    ADDR_CTRL: RDATA_OUT <= ctrl_ff;
                    ADDR_FLAG_TOP: RDATA_OUT <= {1'b0, top_flag_ff};
                    ADDR_FLAG_BUCK: RDATA_OUT <= {2'b00, pok_flag[1:0], short_flag[1:0],
                                                  ilim_flag[1:0]};
                    ADDR_FLAG_LIN: RDATA_OUT <= {2'b00, pok_flag[3:2], short_flag[3:2],
                                                 ilim_flag[3:2]};
                    ADDR_MASK_TOP: RDATA_OUT <= {1'b0, top_mask_ff};
                    ADDR_MASK_BUCK: RDATA_OUT <= {fall_mask_ff[1:0], rise_mask_ff[1:0],
                                                  2'b00, ilim_mask_ff[1:0]};
                    ADDR_MASK_LIN: RDATA_OUT <= {fall_mask_ff[3:2], rise_mask_ff[3:2],
                                                 2'b00, ilim_mask_ff[3:2]};
                    ADDR_STAT_TOP: RDATA_OUT <= {lin_sum, buck_sum, 1'b0, clk_s, pin_ok_ff,
                                                 ovp_s, sd_s, warn_s};
                    ADDR_STAT_RAIL: RDATA_OUT <= {pok_s, ilim_s};
                    default: RDATA_OUT <= RDATA_RST;
                endcase
            end
        end
    end

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    sequence sw_reset_req;
        CE_IN && run && sw_reset;
    endsequence
    sequence boot_walk;
        CE_IN [*3];
    endsequence

    AST_BUCK_ILIM_SET: assert property (
        (CE_IN && run && ilim_s[0] && !ilim_mask_ff[0]) |=> ilim_flag[0])
        else $error("Buck current limit flag not set");
    AST_LIN_ILIM_STICKS: assert property (
        (CE_IN && run && ilim_flag[2] && ilim_s[2] && !ilim_mask_ff[2]) |=> ilim_flag[2])
        else $error("Linear current limit flag cleared while limiting");
    AST_BUCK_SHORT_OFF: assert property (
        $rose(short_flag[1]) |-> !REG_EN_OUT[1] && $past(low_s[1], 1))
        else $error("Buck short flag without disable");
    AST_LIN_SHORT_HIT: assert property (
        (CE_IN && short_hit[2]) |=> short_flag[2] && !REG_EN_OUT[2])
        else $error("Linear short did not disable rail");
    AST_WARN_SET: assert property (
        (CE_IN && run && warn_s && !top_mask_ff[TOP_WARN]) |=> top_flag_ff[TOP_WARN])
        else $error("Die warning flag not set");
    AST_SHUTDOWN_OFF: assert property (
        (CE_IN && run && sd_s) |=> REG_EN_OUT == 4'h0 && !GENERAL_OUTPUT_FIRST_OUT &&
            !GENERAL_OUTPUT_SECOND_OUT && top_flag_ff[TOP_SHUTDOWN])
        else $error("Die shutdown did not stop outputs");
    AST_OVERVOLT_OFF: assert property (
        (CE_IN && run && ovp_s) |=> REG_EN_OUT == 4'h0 && top_flag_ff[TOP_OVERVOLT])
        else $error("Overvoltage did not stop rails");
    AST_LIN_POK_RISE: assert property (
        (CE_IN && run && pok_s[3] && !pok_prev[3] && !rise_mask_ff[3]) |=> pok_flag[3])
        else $error("Power-ok rise flag not set");
    AST_PIN_POLARITY: assert property (
        CE_IN |=> POWER_OK_PIN_OUT == (pin_ok_ff ^ $past(ctrl_ff[CTL_POLARITY], 1)))
        else $error("Pin level does not follow status and polarity");
    AST_INT_LOW: assert property (
        (CE_IN && (|top_flag_ff || buck_sum || lin_sum)) |=> !INTERRUPT_PIN_N_OUT)
        else $error("Interrupt pin not low with flag pending");
    AST_SW_RESET_FLAG: assert property (
        sw_reset_req ##1 boot_walk |=> run && REG_EN_OUT == 4'h0 &&
            top_flag_ff[TOP_RESET] == !top_mask_ff[TOP_RESET])
        else $error("Software reset did not restart with reset flag");

endmodule : pmic_event_interrupt_logic
`default_nettype wire

// ---- tb/pmic_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmic_host_model
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [3:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial
    begin
        addr_out = 4'h0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // Released bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd

    // Read a flag register, then write 1 to every flag seen
    task automatic service(input logic [3:0] a);
        logic [7:0] v;
        rd(a, v);
        wr(a, v);
    endtask : service
endmodule : pmic_host_model
`default_nettype wire

// ---- tb/pmic_event_interrupt_logic_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmic_event_interrupt_logic_bench
    import pmic_irq_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] ilim = 4'h0;
    logic [3:0] low = 4'h0;
    logic [3:0] pok = 4'h0;
    logic [2:0] hot = 3'h0;
    logic syncp = 1'b0;
    logic otp = 1'b0;
    logic meas = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [3:0] en;
    logic g1;
    logic g2;
    logic pin;
    logic irq_n;
    logic [3:0] fa;
    logic [7:0] b;
    int err_count = 0;
    int comparisons = 0;

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    // Short debounce cut to 8 cycles to keep the run brief
    pmic_event_interrupt_logic #(.SHORT_CYCLES(8)) u_pmic_event_interrupt_logic (
        .MCLK_IN(mclk), .RESET_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .ILIM_IN(ilim), .LOW_IN(low),
        .POK_IN(pok), .DIE_WARN_IN(hot[0]), .DIE_SHUTDOWN_IN(hot[1]),
        .OVERVOLT_IN(hot[2]), .SYNC_CLK_PRESENT_IN(syncp), .OTP_RESET_MASK_IN(otp),
        .MEAS_DONE_IN(meas), .RDATA_OUT(rdata), .REG_EN_OUT(en),
        .GENERAL_OUTPUT_FIRST_OUT(g1), .GENERAL_OUTPUT_SECOND_OUT(g2),
        .POWER_OK_PIN_OUT(pin), .INTERRUPT_PIN_N_OUT(irq_n));

    pmic_host_model u_pmic_host_model (
        .clk_in(mclk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic r(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_pmic_host_model.rd(a, v);
        chk(v, exp);
    endtask : r

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        u_pmic_host_model.wr(a, d);
    endtask : w

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // Outputs packed: irq_n, pin, gen outs, rail enables
    task automatic outs(input logic [7:0] exp);
        cyc(2);
        chk({irq_n, pin, g2, g1, en}, exp);
    endtask : outs

    initial
    begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(6);
        outs(8'h40);
        r(ADDR_FLAG_TOP, 8'h40);
        w(ADDR_MASK_TOP, 8'h40);
        r(ADDR_MASK_TOP, 8'h00);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        outs(8'hC0);
        w(4'hF, 8'hFF);
        r(4'hA, 8'h00);
        pok <= 4'hF;
        cyc(4);
        r(ADDR_FLAG_LIN, 8'h30);
        u_pmic_host_model.service(ADDR_FLAG_BUCK);
        u_pmic_host_model.service(ADDR_FLAG_LIN);
        w(ADDR_CTRL, 8'h3F);
        for (int k = 0; k < 4; k++)
        begin
            fa = (k < 2) ? ADDR_FLAG_BUCK : ADDR_FLAG_LIN;
            b = 8'h01 << (k % 2);
            ilim[k] <= 1'b1;
            cyc(4);
            r(fa, b);
            r(ADDR_STAT_RAIL, 8'hF0 | (8'h01 << k));
            r(ADDR_STAT_TOP, (k < 2) ? 8'h48 : 8'h88);
            outs(8'h7F);
            w(fa, b);
            r(fa, b);
            ilim[k] <= 1'b0;
            cyc(4);
            w(fa, b);
            r(fa, 8'h00);
        end
        w(ADDR_MASK_BUCK, 8'h41);
        ilim[0] <= 1'b1;
        cyc(4);
        r(ADDR_FLAG_BUCK, 8'h00);
        ilim[0] <= 1'b0;
        pok[0] <= 1'b0;
        cyc(4);
        r(ADDR_FLAG_BUCK, 8'h00);
        r(ADDR_STAT_TOP, 8'h00);
        pok[0] <= 1'b1;
        cyc(4);
        r(ADDR_FLAG_BUCK, 8'h10);
        r(ADDR_FLAG_TOP, 8'h08);
        u_pmic_host_model.service(ADDR_FLAG_BUCK);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        w(ADDR_CTRL, 8'h7F);
        outs(8'hBF);
        r(ADDR_STAT_TOP, 8'h08);
        w(ADDR_MASK_LIN, 8'h10);
        pok[2] <= 1'b0;
        cyc(4);
        r(ADDR_FLAG_LIN, 8'h10);
        r(ADDR_FLAG_TOP, 8'h08);
        pok[2] <= 1'b1;
        u_pmic_host_model.service(ADDR_FLAG_LIN);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        r(ADDR_FLAG_LIN, 8'h00);
        w(ADDR_CTRL, 8'h3F);
        low[2] <= 1'b1;
        low[1] <= 1'b1;
        outs(8'hFF);
        cyc(10);
        outs(8'h79);
        r(ADDR_FLAG_BUCK, 8'h08);
        r(ADDR_FLAG_LIN, 8'h04);
        low <= 4'h0;
        u_pmic_host_model.service(ADDR_FLAG_BUCK);
        u_pmic_host_model.service(ADDR_FLAG_LIN);
        r(ADDR_FLAG_LIN, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            w(ADDR_CTRL, 8'h3F);
            hot[k] <= 1'b1;
            cyc(4);
            outs((k == 0) ? 8'h7F : 8'h00);
            u_pmic_host_model.service(ADDR_FLAG_TOP);
            r(ADDR_FLAG_TOP, 8'h01 << k);
            hot[k] <= 1'b0;
            cyc(4);
            u_pmic_host_model.service(ADDR_FLAG_TOP);
            r(ADDR_FLAG_TOP, 8'h00);
        end
        syncp <= 1'b1;
        cyc(4);
        r(ADDR_FLAG_TOP, 8'h10);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        w(ADDR_CTRL, 8'h80);
        syncp <= 1'b0;
        cyc(4);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        r(ADDR_FLAG_TOP, 8'h10);
        w(ADDR_CTRL, 8'h3F);
        u_pmic_host_model.service(ADDR_FLAG_TOP);
        meas <= 1'b1;
        @(posedge mclk);
        meas <= 1'b0;
        r(ADDR_FLAG_TOP, 8'h20);
        r(ADDR_STAT_TOP, 8'h08);
        w(ADDR_RESET, 8'h01);
        cyc(6);
        outs(8'h40);
        r(ADDR_FLAG_TOP, 8'h40);
        r(ADDR_CTRL, 8'h00);
        otp <= 1'b1;
        rst_n <= 1'b0;
        #1;
        chk({irq_n, pin, g2, g1, en}, 8'h80);
        cyc(2);
        rst_n <= 1'b1;
        cyc(6);
        r(ADDR_FLAG_TOP, 8'h00);
        r(ADDR_MASK_TOP, 8'h40);
        outs(8'hC0);
        // Strobe seen with the enable low must be dropped
        ce <= 1'b0;
        w(ADDR_CTRL, 8'h3F);
        ce <= 1'b1;
        r(ADDR_CTRL, 8'h00);
        results();
    end
endmodule : pmic_event_interrupt_logic_bench
`default_nettype wire
